// ### ccc_config.v
// Control channel configuration and status logic of the deserializer's I2C slave side.
// Assumes a 25 MHz clk_in, a register port fed by the local serial bus engine,
// and open-drain SCL/SDA resolved outside from the enables.
`timescale 1ns/1ns
`default_nettype none
`include "ccc_map.vh"
module ccc_config #(
   parameter WD_STEP_CYC = `CCC_WD_STEP_NS / `CCC_CLK_NS,
   parameter BUS_LONG_CYC = `CCC_BUS_LONG_NS / `CCC_CLK_NS
) (
   input wire clk_in,
   input wire srst_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_remote_in,
   output reg [7:0] reg_rdata_out,
   input wire scl_in,
   input wire sda_in,
   input wire link_clk_in,
   input wire link_lock_in,
   input wire link_seq_err_in,
   input wire fwd_match_in,
   input wire chan_done_in,
   input wire sda_drive_req_in,
   output reg ack_enable_out,
   output reg chan_fwd_out,
   output reg chan_abort_out,
   output reg bus_free_out,
   output reg scl_out,
   output reg scl_oe_n_out,
   output reg sda_out,
   output reg sda_oe_n_out
);
   localparam BUS_SHORT_CYC = `CCC_BUS_SHORT_NS / `CCC_CLK_NS;
   localparam RECOV_HALF_CYC = `CCC_RECOV_HALF_NS / `CCC_CLK_NS;
   localparam [4:0] RECOV_EDGES = 2 * `CCC_RECOV_CLOCKS;
   localparam ST_IDLE = 3'b001;
   localparam ST_BUSY = 3'b010;
   localparam ST_RECOV = 3'b100;

   // Least time in ns to whole cycles, never under one
   function [7:0] ns_cycles;
      input [31:0] ns;
      reg [31:0] c;
      begin
         c = (ns + `CCC_CLK_NS - 1) / `CCC_CLK_NS;
         if (c == 32'h0)
            c = 32'h1;
         ns_cycles = c[7:0];
      end
   endfunction

   reg [7:0] gen1;
   reg [7:0] wdog;
   reg [7:0] ctl1;
   reg [7:0] ctl2;
   reg [2:0] scl_s, sda_s, lclk_s, lock_s, serr_s;
   reg [1:0] filt;
   reg [7:0] filt_cnt0, filt_cnt1;
   reg [15:0] sda_line;
   reg sda_held, scl_prev, sda_prev, lclk_prev;
   reg [2:0] chan_st;
   reg [31:0] step_cnt;
   reg [6:0] wd_steps;
   reg [31:0] idle_cnt;
   reg [31:0] half_cnt;
   reg [4:0] edges;
   reg [15:0] drv_line;
   reg lock_q;
   wire wr_ok = reg_wr_in & ~(reg_remote_in & ctl2[`CCC_LWD_BIT]);
   wire [7:0] filt_n = ns_cycles(ctl1[`CCC_FILT_HI:`CCC_FILT_LO] * `CCC_FILT_STEP_NS);
   wire [2:0] hold_f = ctl1[`CCC_HOLD_HI:`CCC_HOLD_LO];
   wire [7:0] hold_n = ns_cycles(hold_f * `CCC_HOLD_STEP_NS);
   wire [1:0] dly_f = ctl2[`CCC_SDADLY_HI:`CCC_SDADLY_LO];
   wire [7:0] dly_n = ns_cycles(`CCC_SDADLY_BASE_NS + dly_f * `CCC_SDADLY_STEP_NS);
   wire sda_now = (hold_f == 3'h0) ? filt[1] : sda_line[hold_n[3:0] - 4'h1];
   wire scl_now = filt[0];
   wire start_det = scl_now & scl_prev & sda_prev & ~sda_now;
   wire stop_det = scl_now & scl_prev & ~sda_prev & sda_now;
   wire bus_act = (scl_now != scl_prev) | (sda_now != sda_prev);
   wire [31:0] bus_lim = ctl2[`CCC_SPEED_BIT] ? BUS_SHORT_CYC : BUS_LONG_CYC;
   wire lclk_rise = lclk_s[2] & lclk_s[1] & ~lclk_prev;

   // Registers and the sticky sequence error flag
   always @(posedge clk_in) begin
      if (srst_in) begin
         gen1 <= `CCC_GEN1_RST;
         wdog <= `CCC_WDOG_RST;
         ctl1 <= `CCC_CTL1_RST;
         ctl2 <= `CCC_CTL2_RST;
         reg_rdata_out <= 8'h00;
      end else begin
         if (wr_ok && reg_addr_in == `CCC_OFF_GEN1)
            gen1[`CCC_AUTOACK_BIT] <= reg_wdata_in[`CCC_AUTOACK_BIT];
         if (wr_ok && reg_addr_in == `CCC_OFF_WDOG)
            wdog <= reg_wdata_in;
         if (wr_ok && reg_addr_in == `CCC_OFF_CTL1)
            ctl1 <= reg_wdata_in;
         if (wr_ok && reg_addr_in == `CCC_OFF_CTL2)
            ctl2[`CCC_SEQCLR_BIT:0] <= reg_wdata_in[`CCC_SEQCLR_BIT:0] & 7'h5f;
         // Set beats clear in the same cycle
         if (lclk_rise && lock_q && serr_s[2] == serr_s[1] && serr_s[2]) begin
            ctl2[`CCC_SEQERR_BIT] <= 1'b1;
         end else if (ctl2[`CCC_SEQCLR_BIT]) begin
            ctl2[`CCC_SEQERR_BIT] <= 1'b0;
         end
         case (reg_addr_in)
            `CCC_OFF_GEN1: reg_rdata_out <= gen1;
            `CCC_OFF_WDOG: reg_rdata_out <= wdog;
            `CCC_OFF_CTL1: reg_rdata_out <= ctl1;
            `CCC_OFF_CTL2: reg_rdata_out <= ctl2;
            default: reg_rdata_out <= 8'h00;
         endcase
      end
   end

   // Pin synchronisers; a change counts once stages two and three agree
   always @(posedge clk_in) begin
      if (srst_in) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         lclk_s <= 3'h0;
         lock_s <= 3'h0;
         serr_s <= 3'h0;
         lclk_prev <= 1'b0;
         lock_q <= 1'b0;
         ack_enable_out <= 1'b0;
      end else begin
         scl_s <= {scl_s[1:0], scl_in};
         sda_s <= {sda_s[1:0], sda_in};
         lclk_s <= {lclk_s[1:0], link_clk_in};
         lock_s <= {lock_s[1:0], link_lock_in};
         serr_s <= {serr_s[1:0], link_seq_err_in};
         if (lclk_s[2] == lclk_s[1])
            lclk_prev <= lclk_s[2];
         if (lock_s[2] == lock_s[1])
            lock_q <= lock_s[2];
         ack_enable_out <= gen1[`CCC_AUTOACK_BIT] | lock_q;
      end
   end

   // Glitch filter, then SDA hold delay line
   always @(posedge clk_in) begin
      if (srst_in) begin
         filt <= 2'h3;
         filt_cnt0 <= 8'h00;
         filt_cnt1 <= 8'h00;
         sda_line <= 16'hffff;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         // Input must stay changed for the full depth before it is taken
         if (scl_s[2] != scl_s[1] || scl_s[2] == filt[0])
            filt_cnt0 <= 8'h00;
         else if (filt_cnt0 + 8'h01 >= filt_n) begin
            filt[0] <= scl_s[2];
            filt_cnt0 <= 8'h00;
         end else
            filt_cnt0 <= filt_cnt0 + 8'h01;
         if (sda_s[2] != sda_s[1] || sda_s[2] == filt[1])
            filt_cnt1 <= 8'h00;
         else if (filt_cnt1 + 8'h01 >= filt_n) begin
            filt[1] <= sda_s[2];
            filt_cnt1 <= 8'h00;
         end else
            filt_cnt1 <= filt_cnt1 + 8'h01;
         sda_line <= {sda_line[14:0], filt[1]};
         scl_prev <= scl_now;
         sda_prev <= sda_now;
      end
   end

   // Control channel transaction and its watchdog
   always @(posedge clk_in) begin
      if (srst_in) begin
         chan_st <= ST_IDLE;
         chan_fwd_out <= 1'b0;
         chan_abort_out <= 1'b0;
         step_cnt <= 32'h0;
         wd_steps <= 7'h00;
      end else begin
         chan_abort_out <= 1'b0;
         case (chan_st)
            ST_IDLE: begin
               step_cnt <= 32'h0;
               wd_steps <= 7'h00;
               if (start_det && (ctl1[`CCC_PASSALL_BIT] || fwd_match_in)) begin
                  chan_st <= ST_BUSY;
                  chan_fwd_out <= 1'b1;
               end
            end
            ST_BUSY: begin
               if (stop_det || chan_done_in) begin
                  chan_st <= ST_IDLE;
                  chan_fwd_out <= 1'b0;
               end else if (!wdog[`CCC_WDDIS_BIT] &&
                            wd_steps >= wdog[`CCC_WDTO_HI:`CCC_WDTO_LO]) begin
                  chan_st <= ST_IDLE;
                  chan_fwd_out <= 1'b0;
                  chan_abort_out <= 1'b1;
               end else if (step_cnt >= WD_STEP_CYC - 1) begin
                  step_cnt <= 32'h0;
                  wd_steps <= wd_steps + 7'h01;
               end else
                  step_cnt <= step_cnt + 32'h1;
            end
            default: chan_st <= ST_IDLE;
         endcase
      end
   end

   // Bus watchdog and nine-clock recovery
   always @(posedge clk_in) begin
      if (srst_in) begin
         idle_cnt <= 32'h0;
         half_cnt <= 32'h0;
         edges <= 5'h00;
         bus_free_out <= 1'b0;
         scl_out <= 1'b0;
         scl_oe_n_out <= 1'b1;
      end else if (edges != 5'h00) begin
         // The idle count is held at zero while own SCL pulses run
         idle_cnt <= 32'h0;
         if (half_cnt >= RECOV_HALF_CYC - 1) begin
            half_cnt <= 32'h0;
            edges <= edges - 5'h01;
            // Odd count left opens a low half; the final half leaves SCL released
            scl_oe_n_out <= ~edges[0] | (edges == 5'h01);
         end else
            half_cnt <= half_cnt + 32'h1;
      end else begin
         scl_oe_n_out <= 1'b1;
         if (ctl2[`CCC_BTDIS_BIT] || bus_act) begin
            idle_cnt <= 32'h0;
            bus_free_out <= 1'b0;
         end else if (idle_cnt >= bus_lim - 1) begin
            idle_cnt <= 32'h0;
            if (sda_now)
               bus_free_out <= 1'b1;
            else begin
               edges <= RECOV_EDGES;
               scl_oe_n_out <= 1'b0;
            end
         end else
            idle_cnt <= idle_cnt + 32'h1;
      end
   end

   // SDA output drive request, delayed
   always @(posedge clk_in) begin
      if (srst_in) begin
         drv_line <= 16'h0000;
         sda_out <= 1'b0;
         sda_oe_n_out <= 1'b1;
      end else begin
         drv_line <= {drv_line[14:0], sda_drive_req_in};
         sda_oe_n_out <= ~drv_line[dly_n[3:0] - 4'h2];
      end
   end
endmodule
`default_nettype wire

// ### ccc_far.sv
// Remote serializer model: link clock and transaction completion.
// Assumes chan_fwd_in comes from the block on the same clk_in.
`timescale 1ns/1ns
`default_nettype none
module ccc_far (
   input wire logic clk_in,
   input wire logic chan_fwd_in,
   input wire logic [7:0] done_dly_in,
   output logic link_clk_out,
   output logic chan_done_out
);
   logic [7:0] cnt;
   initial begin
      cnt = 8'h00;
      chan_done_out = 1'b0;
      link_clk_out = 1'b0;
      #7;
      forever #160 link_clk_out = ~link_clk_out;
   end
   // Zero delay models a remote side that never answers
   always @(posedge clk_in) begin
      cnt <= chan_fwd_in ? cnt + 8'h01 : 8'h00;
      chan_done_out <= done_dly_in != 8'h00 && cnt == done_dly_in;
   end
endmodule
`default_nettype wire

// ### ccc_map.vh
// Register map, field positions and timing figures of the control channel
// configuration block. Included by the block's single design file.
// Functional notes
// - Auto-acknowledge bit set: acknowledge regardless of forward lock; clear: follow lock.
// - Control channel watchdog ends transactions that overrun the programmed timeout.
// - Timeout field bits 7:1 counts the watchdog period in 2 ms steps.
// - Watchdog disable bit 0: zero keeps the watchdog on, one turns it off.
// - Pass-all bit 7 forwards every local transaction to the remote serializer.
// - Hold field bits 6:4 delays SDA input against SCL, 50 ns per count.
// - Filter field bits 3:0 sets widest rejected glitch, 5 ns per count.
// - Sequence error in forward channel sets the sticky error flag bit 7.
// - Clear bit 6 held at one clears the flag; software writes it back.
// - SDA output delay field bits 4:3 selects 250, 300, 350 or 400 ns.
// - Local write disable bit 2 blocks remote register writes, not slave access.
// - Speedup bit 1 shortens bus watchdog from about 1 s to 50 us.
// - Watchdog expiry: SDA high means bus free, SDA low drives nine SCL clocks.
// - Bit 0 of the same register disables the bus watchdog.
`ifndef CCC_MAP_VH
`define CCC_MAP_VH
`define CCC_OFF_GEN1 8'h03
`define CCC_OFF_WDOG 8'h04
`define CCC_OFF_CTL1 8'h05
`define CCC_OFF_CTL2 8'h06
`define CCC_GEN1_RST 8'h00
`define CCC_WDOG_RST 8'hfe
`define CCC_CTL1_RST 8'h1e
`define CCC_CTL2_RST 8'h00
`define CCC_AUTOACK_BIT 2
`define CCC_WDDIS_BIT 0
`define CCC_WDTO_HI 7
`define CCC_WDTO_LO 1
`define CCC_PASSALL_BIT 7
`define CCC_HOLD_HI 6
`define CCC_HOLD_LO 4
`define CCC_FILT_HI 3
`define CCC_FILT_LO 0
`define CCC_SEQERR_BIT 7
`define CCC_SEQCLR_BIT 6
`define CCC_SDADLY_HI 4
`define CCC_SDADLY_LO 3
`define CCC_LWD_BIT 2
`define CCC_SPEED_BIT 1
`define CCC_BTDIS_BIT 0
`define CCC_CLK_NS 40
`define CCC_WD_STEP_NS 2000000
`define CCC_HOLD_STEP_NS 50
`define CCC_FILT_STEP_NS 5
`define CCC_SDADLY_BASE_NS 250
`define CCC_SDADLY_STEP_NS 50
`define CCC_BUS_LONG_NS 1000000000
`define CCC_BUS_SHORT_NS 50000
`define CCC_RECOV_HALF_NS 5000
`define CCC_RECOV_CLOCKS 9
`endif

// ### ccc_monitor.sv
// Port checker for the control channel configuration block.
// Assumes it is bound onto ccc_config and clocked by clk_in.
`timescale 1ns/1ns
`default_nettype none
module ccc_monitor (
   input wire clk_in,
   input wire srst_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_remote_in,
   input wire sda_drive_req_in,
   input wire ack_enable_out,
   input wire chan_fwd_out,
   input wire chan_abort_out,
   input wire bus_free_out,
   input wire scl_oe_n_out,
   input wire sda_oe_n_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   sequence s_loc_wr(a, b);
      reg_wr_in && !reg_remote_in && reg_addr_in == a && reg_wdata_in[b];
   endsequence
   sequence s_low_run;
      !scl_oe_n_out [*8];
   endsequence
   sequence s_sda_late;
      sda_oe_n_out [*6] ##[1:5] !sda_oe_n_out;
   endsequence
   property p_ack; s_loc_wr(8'h03, 2) |-> ##[1:2] ack_enable_out; endproperty
   a_ack: assert property (p_ack) else $error("auto ack not seen");
   property p_wd_off; s_loc_wr(8'h04, 0) |-> ##2 !chan_abort_out [*8]; endproperty
   a_wd_off: assert property (p_wd_off) else $error("abort while disabled");
   property p_abort_idle; chan_abort_out |-> ##[0:1] !chan_fwd_out; endproperty
   a_abort_idle: assert property (p_abort_idle) else $error("channel kept after abort");
   property p_abort_pulse; chan_abort_out |-> $past(chan_fwd_out) ##1 !chan_abort_out; endproperty
   a_abort_pulse: assert property (p_abort_pulse) else $error("bad abort pulse");
   property p_recov; $fell(scl_oe_n_out) |-> s_low_run; endproperty
   a_recov: assert property (p_recov) else $error("short recovery low");
   property p_recov_end; $fell(scl_oe_n_out) |-> ##[100:130] scl_oe_n_out; endproperty
   a_recov_end: assert property (p_recov_end) else $error("recovery low too long");
   property p_free; !scl_oe_n_out |-> !bus_free_out; endproperty
   a_free: assert property (p_free) else $error("free during recovery");
   property p_sda; $rose(sda_drive_req_in) |-> s_sda_late; endproperty
   a_sda: assert property (p_sda) else $error("sda delay out of range");
endmodule
bind ccc_config ccc_monitor i_ccc_monitor (.clk_in, .srst_in, .reg_addr_in, .reg_wdata_in,
   .reg_wr_in, .reg_remote_in, .sda_drive_req_in, .ack_enable_out, .chan_fwd_out,
   .chan_abort_out, .bus_free_out, .scl_oe_n_out, .sda_oe_n_out);
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the control channel configuration block.
// Assumes ccc_config, the ccc_far model and the bound ccc_monitor.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_remote_in = 1'b0;
   logic link_lock_in = 1'b0;
   logic link_seq_err_in = 1'b0;
   logic sda_drive_req_in = 1'b0;
   logic m_sda = 1'b1;
   logic [7:0] done_dly = 8'h00;
   wire [7:0] reg_rdata_out;
   wire link_clk_in, chan_done_in, ack_enable_out, chan_fwd_out, chan_abort_out;
   wire bus_free_out, scl_out, scl_oe_n_out, sda_out, sda_oe_n_out;
   // Pull-ups: a released line reads high
   wire scl_in = scl_oe_n_out;
   wire sda_in = m_sda & sda_oe_n_out;
   logic fwd_match_in = 1'b0;
   int n_fail = 0;
   int comparisons = 0;
   int n;
   int i;
   ccc_config #(.WD_STEP_CYC(10), .BUS_LONG_CYC(2000)) i_ccc_config (.clk_in, .srst_in,
      .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_remote_in, .reg_rdata_out, .scl_in, .sda_in,
      .link_clk_in, .link_lock_in, .link_seq_err_in, .fwd_match_in, .chan_done_in,
      .sda_drive_req_in, .ack_enable_out, .chan_fwd_out, .chan_abort_out, .bus_free_out,
      .scl_out, .scl_oe_n_out, .sda_out, .sda_oe_n_out);
   ccc_far i_ccc_far (.clk_in, .chan_fwd_in(chan_fwd_out), .done_dly_in(done_dly),
      .link_clk_out(link_clk_in), .chan_done_out(chan_done_in));
   initial begin
      forever #20 clk_in = ~clk_in;
   end
   task chk(input [15:0] got, input [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d, input r);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      reg_remote_in <= r;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      reg_remote_in <= 1'b0;
   endtask
   task rd(input [7:0] a, input [7:0] exp);
      @(posedge clk_in);
      reg_addr_in <= a;
      repeat (2) @(posedge clk_in);
      chk(reg_rdata_out, exp);
   endtask
   task cnt_low(input int cyc);
      i = 0;
      repeat (cyc) begin
         @(posedge clk_in);
         if (scl_oe_n_out === 1'b0) i++;
      end
   endtask
   task t_reset;
      rd(8'h04, 8'hfe);
      rd(8'h05, 8'h1e);
      rd(8'h06, 8'h00);
      rd(8'h20, 8'h00);
      chk(scl_out, 1'b0);
      chk(sda_out, 1'b0);
   endtask
   task t_chan;
      wr(8'h05, 8'h80, 1'b0);
      wr(8'h04, 8'h02, 1'b0);
      m_sda <= 1'b0;
      for (n = 0; n < 100 && chan_fwd_out !== 1'b1; n++) @(posedge clk_in);
      for (n = 0; n < 100 && chan_abort_out !== 1'b1; n++) @(posedge clk_in);
      chk(n >= 5 && n <= 20, 1'b1);
      @(posedge clk_in);
      chk(chan_fwd_out, 1'b0);
      m_sda <= 1'b1;
      repeat (30) @(posedge clk_in);
      wr(8'h04, 8'h03, 1'b0);
      done_dly <= 8'd60;
      m_sda <= 1'b0;
      for (n = 0; n < 120; n++) begin
         @(posedge clk_in);
         if (n == 40) chk(chan_fwd_out, 1'b1);
      end
      chk(chan_fwd_out, 1'b0);
      m_sda <= 1'b1;
   endtask
   task t_seq;
      chk(ack_enable_out, 1'b0);
      wr(8'h03, 8'h04, 1'b0);
      repeat (3) @(posedge clk_in);
      chk(ack_enable_out, 1'b1);
      link_lock_in <= 1'b1;
      link_seq_err_in <= 1'b1;
      repeat (30) @(posedge clk_in);
      link_seq_err_in <= 1'b0;
      repeat (12) @(posedge clk_in);
      rd(8'h06, 8'h80);
      wr(8'h06, 8'hc0, 1'b0);
      rd(8'h06, 8'h40);
      wr(8'h06, 8'h04, 1'b0);
      wr(8'h05, 8'h55, 1'b1);
      rd(8'h05, 8'h80);
      wr(8'h06, 8'h00, 1'b0);
      wr(8'h05, 8'h1e, 1'b1);
      rd(8'h05, 8'h1e);
   endtask
   task t_sda;
      for (i = 0; i < 4; i++) begin
         wr(8'h06, 8'(i << 3), 1'b0);
         sda_drive_req_in <= 1'b1;
         fwd_match_in <= i[0];
         for (n = 0; n < 30 && sda_oe_n_out !== 1'b0; n++) @(posedge clk_in);
         // Each wait sees the value launched one edge earlier
         chk(n - 1, 7 + i);
         repeat (12) @(posedge clk_in);
         chk(chan_fwd_out, i[0]);
         sda_drive_req_in <= 1'b0;
         fwd_match_in <= 1'b0;
         repeat (20) @(posedge clk_in);
      end
   endtask
   task t_bus;
      wr(8'h06, 8'h02, 1'b0);
      for (n = 0; n < 1500 && bus_free_out !== 1'b1; n++) @(posedge clk_in);
      chk(n > 1100 && n < 1300, 1'b1);
      m_sda <= 1'b0;
      cnt_low(4000);
      chk(i, 9 * 125);
      wr(8'h06, 8'h03, 1'b0);
      cnt_low(3000);
      chk(i, 0);
      m_sda <= 1'b1;
   endtask
   task test_done;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_in);
      srst_in <= 1'b0;
      t_reset;
      t_chan;
      t_seq;
      t_sda;
      t_bus;
      test_done;
   end
   initial begin
      #(40 * 20000);
      n_fail++;
      test_done;
   end
endmodule
`default_nettype wire
